// ### bench/tb_ulpi_host_ctrl.sv
// self-checking bench for the ulpi host controller
// assumes: phy model on the far side, avalon master tasks here
`default_nettype none

module tb_ulpi_host_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, rst_n, rd, wr, waitr, lclk, dir, nxt, oe, stp, role, psw, psoe, refen;
  logic [3:0]  addr, dout, bus_d;
  logic [31:0] wdata, rdata, rdat;
  logic [7:0]  ctl;
  int          miscompares, cmp_count, cyc;
  ulpi_host_ctrl dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_av_address(addr), .i_av_read(rd),
    .i_av_write(wr), .i_av_writedata(wdata), .o_av_readdata(rdata), .o_av_waitrequest(waitr),
    .i_ulpi_clk(lclk), .i_ulpi_dir(dir), .i_ulpi_nxt(nxt), .i_ulpi_data(bus_d),
    .o_ulpi_data(dout), .o_ulpi_data_oe(oe), .o_ulpi_stp(stp), .i_cable_role_pin(role),
    .i_rst_psw(psw), .o_rst_psw(), .o_rst_psw_oe(psoe), .o_ref_clk_en(refen));
  ulpi_phy_model phy (.i_stp(stp), .i_data(dout), .i_oe(oe), .i_psw_oe(psoe), .o_clk(lclk),
    .o_dir(dir), .o_nxt(nxt), .o_wire(bus_d), .o_psw(psw));
  always #12.5 mclk = ~mclk;
  // ------
  // bus and check helpers
  // ------
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    addr  <= a;
    rd    <= !w;
    wr    <= w;
    wdata <= d;
    do @(posedge mclk); while (waitr !== 1'b0);
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic wc(input logic [7:0] v);
    bus(4'h0, 1'b1, {24'h0, v});
  endtask : wc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // polls status until bit b reads v; bounded
  task automatic wst(input int b, input logic v);
    for (int i = 0; i < 300; i++) begin
      bus(4'h8, 1'b0, '0);
      if (rdat[b] === v) break;
    end
    chk({31'h0, rdat[b]}, {31'h0, v});
  endtask : wst
  task automatic cmd(input logic [7:0] tx, input logic [7:0] d, input logic r);
    bus(4'h4, 1'b1, {16'h0, d, tx});
    wc(ctl | {6'h0, r, 1'b1});
    repeat (16) @(posedge mclk);
    wst(0, 1'b0);
  endtask : cmd
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  // ------
  // scenarios
  // ------
  task automatic t_init();
    wst(5, 1'b1);
    // phy keeps dir high through power-up, the reset write follows it
    repeat (120) @(posedge mclk);
    chk({24'h0, phy.regs[4]}, 32'h20);
    bus(4'h8, 1'b0, '0);
    chk({30'h0, rdat[7], rdat[1]}, 32'h2);
    bus(4'h2, 1'b0, '0);
    chk(rdat, '0);
    for (int v = 0; v < 2; v++) begin
      role <= v[0];
      repeat (4) @(posedge mclk);
      bus(4'h8, 1'b0, '0);
      chk({31'h0, rdat[2]}, 32'(v));
    end
    $display("test init done");
  endtask : t_init
  task automatic t_read();
    phy.regs[6'h16] = 8'h5A;
    cmd(8'hD6, 8'h00, 1'b1);
    wst(4, 1'b1);
    bus(4'hC, 1'b0, '0);
    chk({24'h0, rdat[15:8]}, 32'h5A);
    $display("test read done");
  endtask : t_read
  task automatic t_rx();
    fork
      begin
        @(negedge lclk);
        phy.send(8'hA7, 1'b1, 1);
      end
    join_none
    repeat (80) @(posedge mclk);
    bus(4'hC, 1'b0, '0);
    chk({16'h0, rdat[23:16], rdat[7:0]}, 32'hA700);
    fork
      begin
        @(negedge lclk);
        phy.send(8'h3C, 1'b1, 60);
      end
    join_none
    repeat (40) @(posedge mclk);
    wc(ctl | 8'h04);
    repeat (60) @(posedge mclk);
    chk({30'h0, phy.abt, dir}, 32'h2);
    $display("test rx done");
  endtask : t_rx
  task automatic t_lp();
    wc(ctl | 8'h18);
    repeat (2) @(posedge mclk);
    chk({31'h0, refen}, 32'h0);
    wc(ctl | 8'h10);
    bus(4'h0, 1'b0, '0);
    chk({30'h0, rdat[4:3]}, 32'h3);
    wc(ctl | 8'h08);
    wc(ctl);
    chk({31'h0, refen}, 32'h1);
    wc(ctl | 8'h40);
    repeat (6) @(posedge mclk);
    bus(4'h8, 1'b0, '0);
    chk({30'h0, rdat[1], psw}, 32'h2);
    wc(ctl);
    wst(1, 1'b0);
    $display("test power done");
  endtask : t_lp
  task automatic t_vbus();
    ctl = 8'h20;
    wc(ctl);
    cmd(8'hBD, 8'h80, 1'b0);
    cmd(8'h8A, 8'hC0, 1'b0);
    bus(4'h8, 1'b0, '0);
    chk({24'h0, phy.regs[6'h0A]}, 32'hC0);
    chk({30'h0, psw, rdat[6]}, 32'h1);
    ctl = 8'hA0;
    wc(ctl);
    // phy reset left bus noise in rxcmd: start from a clear flag
    bus(4'h8, 1'b1, 32'h8);
    wst(3, 1'b0);
    phy.fault = 1'b1;
    wst(3, 1'b1);
    repeat (200) @(posedge mclk);
    bus(4'hC, 1'b0, '0);
    chk({24'h0, rdat[7:0]}, 32'h01);
    chk({23'h0, psw, phy.regs[6'h0A]}, 32'h180);
    bus(4'h8, 1'b1, 32'h8);
    wst(3, 1'b0);
    $display("test vbus done");
  endtask : t_vbus
  // cycle ceiling well above the run's under one thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    {mclk, rst_n, rd, wr, role} = '0;
    {addr, wdata, ctl} = '0;
    {miscompares, cmp_count, cyc} = '0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_init();
    t_read();
    t_rx();
    t_lp();
    t_vbus();
    end_sim();
  end
endmodule : tb_ulpi_host_ctrl

bind ulpi_host_ctrl ulpi_host_ctrl_sva u_sva (.i_mclk, .i_rst_n, .i_av_read, .i_av_write,
  .o_av_readdata, .o_av_waitrequest, .i_ulpi_dir, .o_ulpi_data, .o_ulpi_data_oe,
  .o_ulpi_stp, .o_rst_psw, .o_rst_psw_oe);

`default_nettype wire

// ### bench/ulpi_host_ctrl_sva.sv
// port checks for the ulpi host controller
// assumes: bound to ulpi_host_ctrl, one i_mclk domain
`default_nettype none

module ulpi_host_ctrl_sva (
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic        i_av_read,
  input wire logic        i_av_write,
  input wire logic [31:0] o_av_readdata,
  input wire logic        o_av_waitrequest,
  input wire logic        i_ulpi_dir,
  input wire logic [3:0]  o_ulpi_data,
  input wire logic        o_ulpi_data_oe,
  input wire logic        o_ulpi_stp,
  input wire logic        o_rst_psw,
  input wire logic        o_rst_psw_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // ------
  // dir high run length, saturating
  // ------
  logic [3:0] dir_cnt;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) dir_cnt <= 4'h0;
    else dir_cnt <= i_ulpi_dir ? dir_cnt + {3'h0, ~&dir_cnt} : 4'h0;
  end
  chk_wait_one: assert property ((i_av_read || i_av_write) && o_av_waitrequest
    |=> !o_av_waitrequest) else $error("request not answered after one wait");
  chk_wait_pulse: assert property (!o_av_waitrequest |=> o_av_waitrequest)
    else $error("waitrequest low too long");
  chk_rdata_hold: assert property ($changed(o_av_readdata)
    |-> !o_av_waitrequest && $past(i_av_read)) else $error("readdata moved");
  chk_idle_zero: assert property ($rose(o_ulpi_data_oe) |-> o_ulpi_data == 4'h0)
    else $error("bus taken with nonzero data");
  chk_release_dir: assert property (dir_cnt == 4'hE |-> !o_ulpi_data_oe)
    else $error("data lines driven while dir high");
  chk_stp_len: assert property ($rose(o_ulpi_stp)
    |-> o_ulpi_stp[*6] ##[1:4] !o_ulpi_stp) else $error("stp not one link cycle");
  chk_stp_data: assert property (o_ulpi_stp && o_ulpi_data_oe
    |-> o_ulpi_data == 4'h0) else $error("data not zero with stp");
  chk_nibble_hold: assert property ($changed(o_ulpi_data)
    |=> $stable(o_ulpi_data)[*2]) else $error("nibble changed mid half cycle");
  chk_od_low: assert property (o_rst_psw_oe |-> !o_rst_psw)
    else $error("shared pin driven high");
  cover property ($rose(o_ulpi_stp));
  cover property (dir_cnt == 4'hE);
  cover property (!o_av_waitrequest && i_av_write);
endmodule : ulpi_host_ctrl_sva

`default_nettype wire

// ### bench/ulpi_phy_model.sv
// behavioural phy: link clock, dir/nxt, registers, fault, power switch
// assumes: link drives data only with i_oe high; bench calls send, sets fault
`default_nettype none

module ulpi_phy_model #(
  parameter logic [5:0] OTG = 6'h0A,
  parameter logic [5:0] PWR = 6'h3D
) (
  input  wire logic       i_stp,
  input  wire logic [3:0] i_data,
  input  wire logic       i_oe,
  input  wire logic       i_psw_oe,
  output logic            o_clk,
  output logic            o_dir,
  output logic            o_nxt,
  output logic [3:0]      o_wire,
  output logic            o_psw
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] regs [64];
  logic [7:0] q [$];
  logic [3:0] lo, pd, last;
  logic       dir_q, dir_p, busy, fault, told, abt, rst;
  // released lines float: show inverse of last driven nibble
  assign o_wire = i_oe ? i_data : (o_dir ? pd : ~last);
  assign o_psw  = !(i_psw_oe || (regs[OTG][6] && regs[PWR][7]));
  assign rst    = !o_psw && !regs[PWR][7];
  assign o_dir  = dir_q || rst;
  initial begin
    foreach (regs[i]) regs[i] = 8'h00;
    {o_clk, o_nxt, busy, fault, told, abt, pd, last} = '0;
    dir_q = 1'b1;
    #1500 dir_q = 1'b0;
  end
  always #100 o_clk = ~o_clk;
  // turnaround, cnt bytes, turnaround back; stp cuts it short
  task automatic send(input logic [7:0] b, input logic n, input int cnt);
    dir_q = 1'b1;
    o_nxt = 1'b0;
    // clock-to-out: outputs move after the edge that samples the old value
    repeat (cnt) begin
      @(negedge o_clk);
      #40;
      pd = b[3:0];
      o_nxt = n;
      @(posedge o_clk);
      abt = i_stp;
      #40;
      pd = b[7:4];
      if (abt) break;
    end
    @(negedge o_clk);
    #40;
    {dir_q, o_nxt} = 2'b00;
  endtask : send
  always @(posedge o_clk) begin
    lo = o_wire;
    if (i_oe) last = i_data;
    if (!o_dir && busy && i_stp) begin
      if (q[0][5:0] == OTG + 6'h2) regs[OTG] &= ~q[1];
      else regs[q[0][5:0]] = q[1];
      {busy, o_nxt} = 2'b00;
      q.delete();
    end else if (!o_dir && !dir_p && !busy && o_wire != 4'h0) begin
      {busy, o_nxt} = 2'b11;
    end
    // dir moved since the last edge: turnaround, lines not valid
    dir_p = o_dir;
  end
  always @(negedge o_clk) begin
    if (!o_dir && busy) q.push_back({o_wire, lo});
    if (q.size() == 1 && q[0][7:6] == 2'b11) begin
      busy = 1'b0;
      send(regs[q[0][5:0]], 1'b0, 1);
      q.delete();
    end else if (!o_dir && !busy && fault != told && regs[OTG][7]) begin
      told = fault;
      send({4'h0, fault ? 2'b00 : 2'b11, 2'b01}, 1'b0, 1);
    end
  end
endmodule : ulpi_phy_model

`default_nettype wire

// ### hw/ulpi_clk_edges.sv
// finds rising and falling edges of the synchronised link clock
// assumes: i_level already passed a synchroniser on i_mclk
`default_nettype none

module ulpi_clk_edges (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_level,
  output logic      o_rise,
  output logic      o_fall
);

  logic prev_reg;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= i_level;
    end
  end

  // combinational so the edge lines up with the synchronised data pins
  assign o_rise = i_level & ~prev_reg;
  assign o_fall = ~i_level & prev_reg;

endmodule : ulpi_clk_edges

`default_nettype wire

// ### hw/ulpi_host_ctrl.sv
// ulpi link-side controller: drives the phy bus, reports over avalon-mm
// assumes: link clock well below i_mclk/4, all phy pins asynchronous to i_mclk
//
// How it works
// - idle bus: link drives data lines to zero
// - nonzero txcmd byte starts every transfer
// - link asserts stp on final cycle
// - stp during dir high aborts, dir drops
// - link enables fault input, sets polarity
// - link sets reset-ignore before power switch
// - vbus state not 11b: clear drive bit
// - role pin high peripheral, low host
// - low power before stopping reference clock
// - link selects exactly one bus mode
// - one turnaround cycle after each dir change
// - low nibble rising, high nibble falling edge
// - link issues reset once clock toggles
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`default_nettype none

`include "ulpi_host_defines.svh"

module ulpi_host_ctrl
  import ulpi_host_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_av_address,
  input  wire logic        i_av_read,
  input  wire logic        i_av_write,
  input  wire logic [31:0] i_av_writedata,
  output logic      [31:0] o_av_readdata,
  output logic             o_av_waitrequest,
  input  wire logic        i_ulpi_clk,
  input  wire logic        i_ulpi_dir,
  input  wire logic        i_ulpi_nxt,
  input  wire logic [3:0]  i_ulpi_data,
  output logic      [3:0]  o_ulpi_data,
  output logic             o_ulpi_data_oe,
  output logic             o_ulpi_stp,
  input  wire logic        i_cable_role_pin,
  input  wire logic        i_rst_psw,
  output logic             o_rst_psw,
  output logic             o_rst_psw_oe,
  output logic             o_ref_clk_en
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] nibble(input logic [7:0] b, input logic hi);
    nibble = hi ? b[7:4] : b[3:0];
  endfunction : nibble

  // ----------------------------------------
  // pin synchronisation and edge finding
  // ----------------------------------------
  logic [`SYNC_WIDTH-1:0] sync_vec;
  logic                   s_clk;
  logic                   s_dir;
  logic                   s_nxt;
  logic [3:0]             s_data;
  logic                   s_role;
  logic                   s_psw;
  logic                   rise;
  logic                   fall;

  ulpi_pin_sync #(
    .WIDTH (`SYNC_WIDTH)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_pins  ({i_ulpi_clk, i_ulpi_dir, i_ulpi_nxt, i_ulpi_data, i_cable_role_pin, i_rst_psw}),
    .o_sync  (sync_vec)
  );

  assign {s_clk, s_dir, s_nxt, s_data, s_role, s_psw} = sync_vec;

  ulpi_clk_edges u_edges (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_level (s_clk),
    .o_rise  (rise),
    .o_fall  (fall)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  host_state_s state_reg;
  host_state_s state_next;
  logic        av_req;
  logic        av_take;
  logic [7:0]  byte_in;
  logic [7:0]  status_byte;

  assign av_req  = i_av_read | i_av_write;
  assign av_take = av_req & ~state_reg.av_wait;
  assign byte_in = {s_data, state_reg.lo_nib};

  always_comb begin
    status_byte                 = 8'h00;
    status_byte[`STAT_BUSY]     = state_reg.pend_sw;
    status_byte[`STAT_DIR]      = s_dir;
    status_byte[`STAT_ROLE]     = s_role;
    status_byte[`STAT_OVC]      = state_reg.ovc;
    status_byte[`STAT_RD_DONE]  = state_reg.rd_done;
    status_byte[`STAT_INIT]     = state_reg.init_done;
    status_byte[`STAT_PSW]      = state_reg.reset_ignore & ~s_psw;
    status_byte[`STAT_REFCLK]   = state_reg.refclk_en;
  end

  always_comb begin
    state_next = state_reg;

    // ----------------------------------------
    // avalon slave: one wait cycle per request
    // ----------------------------------------
    state_next.av_wait = 1'b1;
    if (av_req && state_reg.av_wait) begin
      state_next.av_wait = 1'b0;
    end
    // writes leave readdata alone, so it holds until the next read answer
    if (i_av_read && state_reg.av_wait) begin
      unique case (i_av_address)
        `OFF_CTRL: begin
          state_next.rdata = {24'h000000, state_reg.auto_vbus, state_reg.phy_reset,
                              state_reg.reset_ignore, state_reg.clk_stop_req,
                              state_reg.lp_mode, state_reg.abort_req, state_reg.sw_rd, 1'b0};
        end
        `OFF_CMD:    state_next.rdata = {16'h0000, state_reg.sw_dat, state_reg.sw_tx};
        `OFF_STATUS: state_next.rdata = {24'h000000, status_byte};
        `OFF_RXINFO: begin
          state_next.rdata = {8'h00, state_reg.rx_data, state_reg.rd_data, state_reg.rxcmd};
        end
        default:     state_next.rdata = 32'h00000000;
      endcase
    end

    if (av_take && i_av_write) begin
      unique case (i_av_address)
        `OFF_CTRL: begin
          // register writes carry mode, fault and reset-ignore setup
          if (i_av_writedata[`CTRL_GO] && !state_reg.pend_sw) begin
            state_next.pend_sw = 1'b1;
            state_next.sw_rd   = i_av_writedata[`CTRL_RD];
          end
          // abort only means something while the phy owns the bus
          if (i_av_writedata[`CTRL_ABORT] && state_reg.st == ST_RX) begin
            state_next.abort_req = 1'b1;
          end
          // no leaving low power while the reference clock is stopped
          if (i_av_writedata[`CTRL_LP] || !state_reg.clk_stop_req) begin
            state_next.lp_mode = i_av_writedata[`CTRL_LP];
          end
          state_next.clk_stop_req = i_av_writedata[`CTRL_CLK_STOP];
          state_next.reset_ignore = i_av_writedata[`CTRL_RST_IGN];
          state_next.phy_reset    = i_av_writedata[`CTRL_PHY_RST];
          state_next.auto_vbus    = i_av_writedata[`CTRL_AUTO_VBUS];
        end
        `OFF_CMD: begin
          if (!state_reg.pend_sw) begin
            state_next.sw_tx  = i_av_writedata[7:0];
            state_next.sw_dat = i_av_writedata[15:8];
          end
        end
        `OFF_STATUS: begin
          if (i_av_writedata[`STAT_OVC]) begin
            state_next.ovc = 1'b0;
          end
          if (i_av_writedata[`STAT_RD_DONE]) begin
            state_next.rd_done = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------
    // side pins
    // ----------------------------------------
    // stop the reference clock only once the phy sits in low power
    state_next.refclk_en = ~(state_reg.clk_stop_req & state_reg.lp_mode);
    // never drive the shared pin once it serves as the power switch
    state_next.rst_oe    = state_reg.phy_reset & ~state_reg.reset_ignore;

    // first link clock edge after reset queues the reset write
    if (rise && !state_reg.init_done) begin
      state_next.init_done  = 1'b1;
      state_next.pend_reset = 1'b1;
    end

    // ----------------------------------------
    // link sequencer
    // ----------------------------------------
    unique case (state_reg.st)
      ST_IDLE: begin
        if (rise && s_dir) begin
          // dir just rose: this cycle is turnaround, release the lines
          state_next.d_oe    = 1'b0;
          state_next.have_lo = 1'b0;
          state_next.st      = ST_RX;
        end else if (fall && !s_dir
                     && (state_reg.pend_reset || state_reg.pend_vbus || state_reg.pend_sw)) begin
          if (state_reg.pend_reset) begin
            state_next.src     = SRC_RESET;
            state_next.cur_tx  = `RESET_TXCMD;
            state_next.cur_dat = `RESET_DATA;
            state_next.cur_rd  = 1'b0;
          end else if (state_reg.pend_vbus) begin
            state_next.src     = SRC_VBUS;
            state_next.cur_tx  = `VBUS_OFF_TXCMD;
            state_next.cur_dat = `VBUS_OFF_DATA;
            state_next.cur_rd  = 1'b0;
          end else begin
            state_next.src     = SRC_SW;
            state_next.cur_tx  = state_reg.sw_tx;
            state_next.cur_dat = state_reg.sw_dat;
            state_next.cur_rd  = state_reg.sw_rd;
          end
          state_next.acc = 1'b0;
          state_next.st  = ST_CMD;
          // low nibble set up before the rising edge
          state_next.d_out = state_reg.pend_reset ? nibble(`RESET_TXCMD, 1'b0)
                           : state_reg.pend_vbus  ? nibble(`VBUS_OFF_TXCMD, 1'b0)
                           : nibble(state_reg.sw_tx, 1'b0);
        end else if (rise && !s_dir) begin
          state_next.d_oe  = 1'b1;
          state_next.d_out = 4'h0;
        end
      end

      ST_CMD, ST_DATA: begin
        if (rise && s_dir) begin
          // phy took the bus first; command stays pending and retries
          state_next.d_oe    = 1'b0;
          state_next.have_lo = 1'b0;
          state_next.st      = ST_RX;
        end else if (rise) begin
          state_next.d_out = nibble((state_reg.st == ST_CMD) ? state_reg.cur_tx
                                                               : state_reg.cur_dat, 1'b1);
          state_next.acc   = s_nxt;
        end else if (fall && state_reg.acc) begin
          state_next.acc = 1'b0;
          if (state_reg.st == ST_DATA) begin
            state_next.d_out = 4'h0;
            state_next.stp   = 1'b1;
            state_next.st    = ST_STP;
          end else if (state_reg.cur_rd) begin
            state_next.d_out = 4'h0;
            state_next.st    = ST_RD_TURN;
          end else begin
            state_next.d_out = nibble(state_reg.cur_dat, 1'b0);
            state_next.st    = ST_DATA;
          end
        end else if (fall) begin
          state_next.d_out = nibble((state_reg.st == ST_CMD) ? state_reg.cur_tx
                                                               : state_reg.cur_dat, 1'b0);
        end
      end

      ST_STP: begin
        if (fall) begin
          state_next.stp = 1'b0;
          state_next.st  = ST_IDLE;
          unique case (state_reg.src)
            SRC_RESET: state_next.pend_reset = 1'b0;
            SRC_VBUS:  state_next.pend_vbus  = 1'b0;
            SRC_SW:    state_next.pend_sw    = 1'b0;
            default:   state_next.pend_sw    = 1'b0;
          endcase
        end
      end

      ST_RD_TURN: begin
        if (rise && s_dir) begin
          state_next.d_oe    = 1'b0;
          state_next.have_lo = 1'b0;
          state_next.st      = ST_RD_BYTE;
        end
      end

      ST_RD_BYTE: begin
        if (rise) begin
          state_next.lo_nib  = s_data;
          state_next.have_lo = 1'b1;
        end else if (fall && state_reg.have_lo) begin
          state_next.rd_data = byte_in;
          state_next.rd_done = 1'b1;
          state_next.pend_sw = 1'b0;
          state_next.have_lo = 1'b0;
          state_next.st      = ST_TURN;
        end
      end

      ST_RX: begin
        if (rise && !s_dir) begin
          // dir fell: turnaround is over by this edge, take the bus back
          state_next.d_oe    = 1'b1;
          state_next.d_out   = 4'h0;
          state_next.stp     = 1'b0;
          state_next.have_lo = 1'b0;
          state_next.st      = ST_IDLE;
          state_next.abort_req = 1'b0;
        end else if (rise) begin
          state_next.lo_nib  = s_data;
          state_next.lo_nxt  = s_nxt;
          state_next.have_lo = 1'b1;
        end else if (fall) begin
          // one-cycle abort strobe while the phy owns the bus
          state_next.stp = state_reg.abort_req;
          // only a consumed request clears; a write landing with no request pending survives
          if (state_reg.abort_req) begin
            state_next.abort_req = 1'b0;
          end
          if (state_reg.have_lo) begin
            state_next.have_lo = 1'b0;
            if (state_reg.lo_nxt) begin
              state_next.rx_data = byte_in;
            end else begin
              state_next.rxcmd = byte_in;
              // any vbus state other than good counts as overcurrent
              if (byte_in[`RXCMD_VBUS_LSB +: 2] != `VBUS_GOOD) begin
                state_next.ovc = 1'b1;
                if (state_reg.auto_vbus) begin
                  state_next.pend_vbus = 1'b1;
                end
              end
            end
          end
        end
      end

      ST_TURN: begin
        if (rise && !s_dir) begin
          state_next.d_oe  = 1'b1;
          state_next.d_out = 4'h0;
          state_next.st    = ST_IDLE;
        end
      end

      default: begin
        state_next.st   = ST_IDLE;
        state_next.d_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg           <= '0;
      state_reg.st        <= ST_IDLE;
      state_reg.src       <= SRC_RESET;
      state_reg.refclk_en <= 1'b1;
      state_reg.av_wait   <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_av_readdata    = state_reg.rdata;
  assign o_av_waitrequest = state_reg.av_wait;
  assign o_ulpi_data      = state_reg.d_out;
  assign o_ulpi_data_oe   = state_reg.d_oe;
  assign o_ulpi_stp       = state_reg.stp;
  assign o_rst_psw        = 1'b0;
  assign o_rst_psw_oe     = state_reg.rst_oe;
  assign o_ref_clk_en     = state_reg.refclk_en;

endmodule : ulpi_host_ctrl

`default_nettype wire

// ### hw/ulpi_host_defines.svh
// offsets, field positions and fixed codes of the ulpi host
// assumes: included by bare name from every file that decodes registers
`ifndef ULPI_HOST_DEFINES_SVH
`define ULPI_HOST_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_CTRL        4'h0
`define OFF_CMD         4'h4
`define OFF_STATUS      4'h8
`define OFF_RXINFO      4'hC

// ----------------------------------------
// control bits
// ----------------------------------------
`define CTRL_GO         0
`define CTRL_RD         1
`define CTRL_ABORT      2
`define CTRL_LP         3
`define CTRL_CLK_STOP   4
`define CTRL_RST_IGN    5
`define CTRL_PHY_RST    6
`define CTRL_AUTO_VBUS  7

// ----------------------------------------
// status bits
// ----------------------------------------
`define STAT_BUSY       0
`define STAT_DIR        1
`define STAT_ROLE       2
`define STAT_OVC        3
`define STAT_RD_DONE    4
`define STAT_INIT       5
`define STAT_PSW        6
`define STAT_REFCLK     7

// ----------------------------------------
// link codes
// ----------------------------------------
`define RXCMD_VBUS_LSB  2
`define VBUS_GOOD       2'h3
`define RESET_TXCMD     8'h84
`define RESET_DATA      8'h20
`define VBUS_OFF_TXCMD  8'h8C
`define VBUS_OFF_DATA   8'h40
`define SYNC_WIDTH      9

`endif

// ### hw/ulpi_host_pkg.sv
// types shared by the ulpi host controller
// assumes: compiled before every module that imports it
`default_nettype none

package ulpi_host_pkg;

  // ----------------------------------------
  // link sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_CMD     = 4'h1,
    ST_DATA    = 4'h2,
    ST_STP     = 4'h3,
    ST_RD_TURN = 4'h4,
    ST_RD_BYTE = 4'h5,
    ST_RX      = 4'h6,
    ST_TURN    = 4'h7
  } link_state_e;

  typedef enum logic [1:0] {
    SRC_RESET = 2'h0,
    SRC_VBUS  = 2'h1,
    SRC_SW    = 2'h2
  } cmd_src_e;

  // ----------------------------------------
  // whole controller state
  // ----------------------------------------
  typedef struct packed {
    link_state_e st;
    cmd_src_e    src;
    logic        cur_rd;
    logic [7:0]  cur_tx;
    logic [7:0]  cur_dat;
    logic        acc;
    logic [3:0]  d_out;
    logic        d_oe;
    logic        stp;
    logic [3:0]  lo_nib;
    logic        lo_nxt;
    logic        have_lo;
    logic [7:0]  rxcmd;
    logic [7:0]  rd_data;
    logic [7:0]  rx_data;
    logic        ovc;
    logic        rd_done;
    logic        init_done;
    logic        pend_reset;
    logic        pend_vbus;
    logic        pend_sw;
    logic        sw_rd;
    logic [7:0]  sw_tx;
    logic [7:0]  sw_dat;
    logic        lp_mode;
    logic        clk_stop_req;
    logic        reset_ignore;
    logic        phy_reset;
    logic        auto_vbus;
    logic        abort_req;
    logic        refclk_en;
    logic        rst_oe;
    logic        av_wait;
    logic [31:0] rdata;
  } host_state_s;

endpackage : ulpi_host_pkg

`default_nettype wire

// ### hw/ulpi_pin_sync.sv
// two-flop synchroniser for a group of pins
// assumes: each bit is an independent level from outside the i_mclk domain
`default_nettype none

module ulpi_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_pins,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_pins;
      o_sync   <= meta_reg;
    end
  end

endmodule : ulpi_pin_sync

`default_nettype wire
